// *** core/usbdec_ep0mem.sv ***
// eight byte data store of the control endpoint, registered read
`timescale 1ns/1ps
module usbdec_ep0mem import usbdec_pkg::*; #(
	parameter int DEPTH = EP0_BYTES,
	parameter int AW = EP0_AW
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic wr_i,
	input wire logic [AW-1:0] waddr_i,
	input wire logic [7:0] wdata_i,
	input wire logic [AW-1:0] raddr_i,
	output logic [7:0] rdata_o
);
	logic [7:0] mem [DEPTH];

	// storage has no reset; only the read register does
	always_ff @(posedge clk_i) begin
		if (wr_i) begin
			mem[waddr_i] <= wdata_i;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rdata_o <= 8'h00;
		end else begin
			rdata_o <= mem[raddr_i];
		end
	end
endmodule : usbdec_ep0mem

// *** core/usbdec_timer.sv ***
// event counter that pulses once when a running count reaches its limit
`timescale 1ns/1ps
module usbdec_timer import usbdec_pkg::*; #(
	parameter int W = 10
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	usbdec_tmr_if.tmr t
);
	logic [W-1:0] count;
	logic fired;
	logic hit;
	wire [W-1:0] next_count = count + 1'b1;
	wire reach = t.run && t.tick && !fired && (next_count >= t.limit);
	assign t.hit = hit;

	// count ticks while running; dropping run restarts from zero
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			count <= '0;
			fired <= 1'b0;
			hit <= 1'b0;
		end else begin
			hit <= reach;
			if (!t.run) begin
				count <= '0;
				fired <= 1'b0;
			end else if (t.tick && !fired) begin
				count <= next_count;
				fired <= reach;
			end
		end
	end

	property p_hit_once;
		@(posedge clk_i) disable iff (!rstn_i)
		hit |=> !hit;
	endproperty
	a_hit_once: assert property (p_hit_once) else $error("counter hit repeated");
endmodule : usbdec_timer

// *** core/usbdec_top.sv ***
// usb device control, endpoint setup and event/interrupt logic
// ------------------------------------------------------------
// How it works
// - pull-up enable bit drives the D+ pull-up control output
// - pad select one gives D+/D- to general I/O, zero to usb
// - supply change sets sticky cause bit 5; mask raises irq; write one clears
// - supply present bit 5 reads one while supply is present
// - link power control: enable, handshake reply, reply to other sub-pid
// - lpm token captures BESL and remote wake into status
// - eight data endpoints plus control endpoint zero
// - in manual memory mode endpoint-active bits are ignored
// - per-endpoint direction bit selects IN or OUT
// - control endpoint has its own eight byte store
// - fourteen causes each routed by a level field to one of three lines
// - each line has a cause register showing its driving sources
// - SOF sets frame-start raw bit; irq only when masked in
// - masked status equals mask AND raw
// - no SOF for 3 ms enters suspend
// - SE0 starts peripheral-clock counter; reaching count raises bus reset
// - bus reset has raw, mask and masked bits
// - each data endpoint has enable bit and status bit
// - endpoint interrupts on done, enabled NAK, and error with flag
// - stall bit plus matching packet and ack mode gives stall event
// - ep0 interrupts on done and SETUP; software can force it
// - lpm token raises lpm event with raw, mask, masked bits
// - zero on D+ raises resume, only in active mode while suspended
`timescale 1ns/1ps
module usbdec_top import usbdec_pkg::*; #(
	parameter int SUSPEND_CYCLES = SUSPEND_CYC,
	parameter int PERI_DIV = PERI_DIV_DEF
) (
	input wire logic CLK_SYS_I,
	input wire logic RSTN_I,
	input wire logic PULLUP_EN_I,
	input wire logic PAD_FUNC_SEL_I,
	input wire logic SUPPLY_LEVEL_I,
	input wire logic [SUP_W-1:0] SUPPLY_MASK_I,
	input wire logic [SUP_W-1:0] SUPPLY_CLR_I,
	input wire logic LPM_ENABLE_I,
	input wire logic [1:0] LPM_HANDSHAKE_I,
	input wire logic [1:0] LPM_OTHER_RESP_I,
	input wire logic LPM_TOKEN_I,
	input wire logic LPM_OTHER_I,
	input wire logic [BESL_W-1:0] LPM_BESL_I,
	input wire logic LPM_RWAKE_I,
	input wire logic AUTO_MEM_I,
	input wire logic [NUM_EP-1:0] ENDPOINT_ACTIVE_REG_I,
	input wire logic [NUM_EP-1:0] EP_DIR_IN_I,
	input wire logic EP0_WR_I,
	input wire logic [EP0_AW-1:0] EP0_WADDR_I,
	input wire logic [7:0] EP0_WDATA_I,
	input wire logic [EP0_AW-1:0] EP0_RADDR_I,
	input wire logic [NUM_CAUSE*LVL_W-1:0] LVL_SEL_I,
	input wire logic [ENG_W-1:0] ENG_MASK_I,
	input wire logic [ENG_W-1:0] ENG_CLR_I,
	input wire logic [ENG_W-1:0] ENG_FORCE_I,
	input wire logic SOF_I,
	input wire logic SE0_I,
	input wire logic [RST_CNT_W-1:0] BUS_RST_CNT_I,
	input wire logic DP_LEVEL_I,
	input wire logic ACTIVE_MODE_I,
	input wire logic EP0_DONE_I,
	input wire logic EP0_SETUP_I,
	input wire logic [NUM_EP-1:0] EP_INT_EN_I,
	input wire logic [NUM_EP-1:0] EP_INT_CLR_I,
	input wire logic [NUM_EP-1:0] EP_DONE_I,
	input wire logic [NUM_EP-1:0] EP_NAK_I,
	input wire logic [NUM_EP-1:0] EP_NAK_EN_I,
	input wire logic [NUM_EP-1:0] EP_ERR_I,
	input wire logic [NUM_EP-1:0] EP_STALL_BIT_I,
	input wire logic [NUM_EP-1:0] EP_ACK_OUT_I,
	input wire logic [NUM_EP-1:0] EP_ACK_IN_I,
	input wire logic [NUM_EP-1:0] EP_OUT_PKT_I,
	input wire logic [NUM_EP-1:0] EP_IN_PKT_I,
	output logic PULLUP_ON_O,
	output logic PAD_GPIO_O,
	output logic [SUP_W-1:0] SUPPLY_CAUSE_O,
	output logic [SUP_W-1:0] SUPPLY_PRESENT_O,
	output logic LPM_RESP_VALID_O,
	output logic [1:0] LPM_RESP_O,
	output logic [BESL_W-1:0] LPM_BESL_O,
	output logic LPM_RWAKE_O,
	output logic [NUM_EP-1:0] EP_ENABLED_O,
	output logic [NUM_EP-1:0] EP_IS_IN_O,
	output logic [7:0] EP0_RDATA_O,
	output logic [ENG_W-1:0] ENG_RAW_O,
	output logic [ENG_W-1:0] ENG_MASKED_O,
	output logic [NUM_EP-1:0] EP_INT_SR_O,
	output logic [NUM_EP-1:0] EP_ERR_FLAG_O,
	output logic SUSPEND_O,
	output logic [NUM_CAUSE-1:0] CAUSE_LOW_O,
	output logic [NUM_CAUSE-1:0] CAUSE_MED_O,
	output logic [NUM_CAUSE-1:0] CAUSE_HIGH_O,
	output logic IRQ_LOW_O,
	output logic IRQ_MED_O,
	output logic IRQ_HIGH_O
);
	// ------------------------------------------------------------
	// peripheral clock enable and counters
	// ------------------------------------------------------------
	localparam logic [7:0] PERI_LAST = 8'(PERI_DIV - 1);
	localparam logic [SUSP_W-1:0] SUSP_LIMIT = SUSP_W'(SUSPEND_CYCLES);
	logic [7:0] div_cnt;
	logic peri_tick;
	usbdec_tmr_if #(.W(RST_CNT_W)) brst_t ();
	usbdec_tmr_if #(.W(SUSP_W)) susp_t ();

	// one-cycle enable stands in for the slower peripheral clock
	always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			div_cnt <= 8'h00;
			peri_tick <= 1'b0;
		end else begin
			peri_tick <= (div_cnt == PERI_LAST);
			div_cnt <= (div_cnt == PERI_LAST) ? 8'h00 : div_cnt + 8'h01;
		end
	end

	// SE0 runs the bus reset counter on the peripheral tick
	assign brst_t.run = SE0_I;
	assign brst_t.tick = peri_tick;
	assign brst_t.limit = BUS_RST_CNT_I;
	// every SOF restarts the idle-frame counter
	assign susp_t.run = !SOF_I;
	assign susp_t.tick = 1'b1;
	assign susp_t.limit = SUSP_LIMIT;

	usbdec_timer #(.W(RST_CNT_W)) u_brst (
		.clk_i(CLK_SYS_I),
		.rstn_i(RSTN_I),
		.t(brst_t)
	);
	usbdec_timer #(.W(SUSP_W)) u_susp (
		.clk_i(CLK_SYS_I),
		.rstn_i(RSTN_I),
		.t(susp_t)
	);

	// control endpoint store is apart from the shared data buffer
	usbdec_ep0mem u_ep0 (
		.clk_i(CLK_SYS_I),
		.rstn_i(RSTN_I),
		.wr_i(EP0_WR_I),
		.waddr_i(EP0_WADDR_I),
		.wdata_i(EP0_WDATA_I),
		.raddr_i(EP0_RADDR_I),
		.rdata_o(EP0_RDATA_O)
	);

	// ------------------------------------------------------------
	// event decode
	// ------------------------------------------------------------
	logic supply_q;
	wire supply_chg = SUPPLY_LEVEL_I != supply_q;
	wire resume_evt = !DP_LEVEL_I && ACTIVE_MODE_I && SUSPEND_O;
	wire ep0_evt = EP0_DONE_I || EP0_SETUP_I;
	wire [ENG_W-1:0] eng_evt = {resume_evt, LPM_TOKEN_I, ep0_evt,
		brst_t.hit, SOF_I};
	// set wins over clear so a coincident event is kept
	wire [ENG_W-1:0] next_raw = eng_evt | ENG_FORCE_I |
		(ENG_RAW_O & ~ENG_CLR_I);
	wire [ENG_W-1:0] next_masked = next_raw & ENG_MASK_I;
	wire [SUP_W-1:0] sup_set = SUP_W'(supply_chg) << SUPPLY_POS;
	wire [SUP_W-1:0] next_sup = sup_set | (SUPPLY_CAUSE_O & ~SUPPLY_CLR_I);
	wire sup_irq = |(next_sup & SUPPLY_MASK_I);
	// manual memory mode treats every endpoint as usable
	wire [NUM_EP-1:0] ep_use = AUTO_MEM_I ? ENDPOINT_ACTIVE_REG_I : '1;
	logic [NUM_EP-1:0] ep_evt;
	logic [NUM_EP-1:0] next_sr;
	logic [NUM_EP-1:0] next_err;

	// per endpoint event sources
	genvar g;
	generate
		for (g = 0; g < NUM_EP; g++) begin : g_ep
			wire stall_evt = EP_STALL_BIT_I[g] &&
				((EP_OUT_PKT_I[g] && EP_ACK_OUT_I[g]) ||
				(EP_IN_PKT_I[g] && EP_ACK_IN_I[g]));
			assign ep_evt[g] = ep_use[g] && (EP_DONE_I[g] ||
				(EP_NAK_I[g] && EP_NAK_EN_I[g]) ||
				EP_ERR_I[g] || stall_evt);
			assign next_sr[g] = ep_evt[g] ||
				(EP_INT_SR_O[g] && !EP_INT_CLR_I[g]);
			assign next_err[g] = (ep_use[g] && EP_ERR_I[g]) ||
				(EP_ERR_FLAG_O[g] && !EP_INT_CLR_I[g]);
		end
	endgenerate

	// ------------------------------------------------------------
	// level routing of the fourteen causes
	// ------------------------------------------------------------
	wire [NUM_CAUSE-1:0] cause = {next_sr & EP_INT_EN_I, sup_irq,
		next_masked};
	logic [NUM_CAUSE-1:0] to_low;
	logic [NUM_CAUSE-1:0] to_med;
	logic [NUM_CAUSE-1:0] to_high;

	// a level field of two or three sends the cause to the high line
	generate
		for (g = 0; g < NUM_CAUSE; g++) begin : g_route
			wire [LVL_W-1:0] lvl = LVL_SEL_I[g*LVL_W +: LVL_W];
			assign to_low[g] = cause[g] && (lvl == LVL_LOW);
			assign to_med[g] = cause[g] && (lvl == LVL_MED);
			assign to_high[g] = cause[g] && (lvl != LVL_LOW) &&
				(lvl != LVL_MED);
		end
	endgenerate

	// ------------------------------------------------------------
	// status registers
	// ------------------------------------------------------------
	// sticky flags, masked copies and line causes share one edge
	always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			ENG_RAW_O <= '0;
			ENG_MASKED_O <= '0;
			SUPPLY_CAUSE_O <= SUP_ZERO;
			EP_INT_SR_O <= '0;
			EP_ERR_FLAG_O <= '0;
			CAUSE_LOW_O <= '0;
			CAUSE_MED_O <= '0;
			CAUSE_HIGH_O <= '0;
			IRQ_LOW_O <= 1'b0;
			IRQ_MED_O <= 1'b0;
			IRQ_HIGH_O <= 1'b0;
		end else begin
			ENG_RAW_O <= next_raw;
			ENG_MASKED_O <= next_masked;
			SUPPLY_CAUSE_O <= next_sup;
			EP_INT_SR_O <= next_sr;
			EP_ERR_FLAG_O <= next_err;
			CAUSE_LOW_O <= to_low;
			CAUSE_MED_O <= to_med;
			CAUSE_HIGH_O <= to_high;
			IRQ_LOW_O <= |to_low;
			IRQ_MED_O <= |to_med;
			IRQ_HIGH_O <= |to_high;
		end
	end

	// ------------------------------------------------------------
	// pads, supply, endpoints, suspend
	// ------------------------------------------------------------
	// static controls are registered so every output is a flop
	always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			PULLUP_ON_O <= 1'b0;
			PAD_GPIO_O <= 1'b0;
			supply_q <= 1'b0;
			SUPPLY_PRESENT_O <= SUP_ZERO;
			EP_ENABLED_O <= '0;
			EP_IS_IN_O <= '0;
			SUSPEND_O <= 1'b0;
		end else begin
			PULLUP_ON_O <= PULLUP_EN_I;
			PAD_GPIO_O <= PAD_FUNC_SEL_I;
			supply_q <= SUPPLY_LEVEL_I;
			SUPPLY_PRESENT_O <= SUP_W'(SUPPLY_LEVEL_I) << SUPPLY_POS;
			EP_ENABLED_O <= ep_use;
			EP_IS_IN_O <= EP_DIR_IN_I;
			if (SOF_I || brst_t.hit) begin
				SUSPEND_O <= 1'b0;
			end else if (susp_t.hit) begin
				SUSPEND_O <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// link power management
	// ------------------------------------------------------------
	// the reply pulses one cycle after the token or other sub-pid
	always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			LPM_RESP_VALID_O <= 1'b0;
			LPM_RESP_O <= LPM_RESP_NONE;
			LPM_BESL_O <= '0;
			LPM_RWAKE_O <= 1'b0;
		end else begin
			LPM_RESP_VALID_O <= LPM_TOKEN_I || LPM_OTHER_I;
			if (LPM_TOKEN_I) begin
				LPM_RESP_O <= LPM_ENABLE_I ? LPM_HANDSHAKE_I
					: LPM_RESP_NONE;
				LPM_BESL_O <= LPM_BESL_I;
				LPM_RWAKE_O <= LPM_RWAKE_I;
			end else if (LPM_OTHER_I) begin
				LPM_RESP_O <= LPM_OTHER_RESP_I;
			end
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (!RSTN_I);

	property p_pullup;
		PULLUP_EN_I |=> PULLUP_ON_O;
	endproperty
	a_pullup: assert property (p_pullup) else $error("pull-up off");
	property p_pad;
		##1 PAD_GPIO_O == $past(PAD_FUNC_SEL_I);
	endproperty
	a_pad: assert property (p_pad) else $error("pad select wrong");
	property p_supply;
		(SUPPLY_LEVEL_I != supply_q) |=> SUPPLY_CAUSE_O[SUPPLY_POS];
	endproperty
	a_supply: assert property (p_supply) else $error("supply lost");
	property p_present;
		##1 SUPPLY_PRESENT_O[SUPPLY_POS] == $past(SUPPLY_LEVEL_I);
	endproperty
	a_present: assert property (p_present) else $error("presence");
	property p_lpm_cap;
		LPM_TOKEN_I |=> LPM_BESL_O == $past(LPM_BESL_I) && LPM_RESP_VALID_O;
	endproperty
	a_lpm_cap: assert property (p_lpm_cap) else $error("besl");
	property p_manual;
		!AUTO_MEM_I |=> &EP_ENABLED_O;
	endproperty
	a_manual: assert property (p_manual) else $error("active used");
	property p_sof;
		SOF_I |=> ENG_RAW_O[ENG_SOF] &&
			(ENG_MASKED_O[ENG_SOF] == $past(ENG_MASK_I[ENG_SOF]));
	endproperty
	a_sof: assert property (p_sof) else $error("sof flag");
	property p_masked;
		ENG_MASKED_O == (ENG_RAW_O & $past(ENG_MASK_I));
	endproperty
	a_masked: assert property (p_masked) else $error("masked");
	property p_suspend;
		susp_t.hit && !SOF_I && !brst_t.hit |=> SUSPEND_O;
	endproperty
	a_suspend: assert property (p_suspend) else $error("no suspend");
	property p_stall;
		EP_STALL_BIT_I[0] && EP_OUT_PKT_I[0] && EP_ACK_OUT_I[0] &&
			ep_use[0] |=> EP_INT_SR_O[0];
	endproperty
	a_stall: assert property (p_stall) else $error("stall lost");
	property p_line;
		IRQ_LOW_O == |CAUSE_LOW_O && IRQ_HIGH_O == |CAUSE_HIGH_O;
	endproperty
	a_line: assert property (p_line) else $error("line mismatch");

	c_brst: cover property (brst_t.hit ##1 ENG_RAW_O[ENG_BRST]);
	c_susp: cover property (susp_t.hit ##1 SUSPEND_O);
	c_high: cover property (IRQ_HIGH_O && IRQ_LOW_O);
endmodule : usbdec_top

// *** shared/usbdec_pkg.sv ***
// shared constants of the usb device event and control block
package usbdec_pkg;
	// ------------------------------------------------------------
	// sizes
	// ------------------------------------------------------------
	localparam int NUM_EP = 8;
	localparam int NUM_CAUSE = 14;
	localparam int EP0_BYTES = 8;
	localparam int EP0_AW = 3;
	localparam int LVL_W = 2;
	localparam int ENG_W = 5;
	localparam int SUP_W = 8;
	localparam int BESL_W = 4;
	localparam int RST_CNT_W = 10;
	localparam int SUSP_W = 20;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_FREQ_MHZ = 100;
	localparam int SUSPEND_TIME_US = 3000;
	localparam int SUSPEND_CYC = SUSPEND_TIME_US * CLK_FREQ_MHZ;
	localparam int PERI_DIV_DEF = 4;
	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int SUPPLY_POS = 5;
	localparam int ENG_SOF = 0;
	localparam int ENG_BRST = 1;
	localparam int ENG_EP0 = 2;
	localparam int ENG_LPM = 3;
	localparam int ENG_RESUME = 4;
	localparam int CAUSE_SUPPLY = 5;
	localparam int CAUSE_EP1 = 6;
	// ------------------------------------------------------------
	// encodings
	// ------------------------------------------------------------
	localparam logic [LVL_W-1:0] LVL_LOW = 2'h0;
	localparam logic [LVL_W-1:0] LVL_MED = 2'h1;
	localparam logic [1:0] LPM_RESP_NONE = 2'h0;
	localparam logic [SUP_W-1:0] SUP_ZERO = 8'h00;
endpackage : usbdec_pkg

// *** shared/usbdec_tmr_if.sv ***
// carrier between the control logic and one event counter
`timescale 1ns/1ps
interface usbdec_tmr_if #(parameter int W = 10);
	logic run;
	logic tick;
	logic [W-1:0] limit;
	logic hit;
	modport ctrl (output run, output tick, output limit, input hit);
	modport tmr (input run, input tick, input limit, output hit);
endinterface : usbdec_tmr_if

// *** verification/usbdec_host_model.sv ***
// behavioural usb host: frames, bus reset, lpm tokens and wake signalling
`timescale 1ns/1ps
module usbdec_host_model import usbdec_pkg::*; (
	input wire logic clk_i,
	output logic sof_o,
	output logic se0_o,
	output logic lpm_token_o,
	output logic lpm_other_o,
	output logic [BESL_W-1:0] lpm_besl_o,
	output logic lpm_rwake_o,
	output logic dp_level_o
);
	// idle bus is J, so D+ sits high; token payload starts as junk
	initial begin
		{sof_o, se0_o, lpm_token_o, lpm_other_o} = 4'h0;
		lpm_besl_o = 4'hA;
		lpm_rwake_o = 1'b1;
		dp_level_o = 1'b1;
	end
	// one start-of-frame packet, one cycle wide
	task automatic sof();
		@(posedge clk_i);
		#1;
		sof_o = 1'b1;
		@(posedge clk_i);
		#1;
		sof_o = 1'b0;
	endtask : sof
	// se0 pulls both lines low, so D+ drops as well
	task automatic se0(input logic on);
		@(posedge clk_i);
		#1;
		se0_o = on;
		dp_level_o = !on;
	endtask : se0
	// resume signalling: D+ held low for n cycles
	task automatic wake(input int n);
		@(posedge clk_i);
		#1;
		dp_level_o = 1'b0;
		repeat (n) @(posedge clk_i);
		#1;
		dp_level_o = 1'b1;
	endtask : wake
	// payload is inverted after the token so a late sample cannot match
	task automatic tok(input logic oth, input logic [BESL_W-1:0] b,
		input logic rw);
		@(posedge clk_i);
		#1;
		lpm_token_o = !oth;
		lpm_other_o = oth;
		lpm_besl_o = b;
		lpm_rwake_o = rw;
		@(posedge clk_i);
		#1;
		{lpm_token_o, lpm_other_o} = 2'h0;
		lpm_besl_o = ~b;
		lpm_rwake_o = !rw;
	endtask : tok
endmodule : usbdec_host_model

// *** verification/usbdec_top_tb_top.sv ***
// self-checking bench of the usb device event and control block
`timescale 1ns/1ps
module usbdec_top_tb_top import usbdec_pkg::*;;
	logic clk = 0, rstn = 0, pu, pad, sup, lpm_en, auto_m, e0wr, act;
	logic e0done, e0setup;
	logic [1:0] hs, oth;
	logic [2:0] wa, ra;
	logic [3:0] b;
	logic [7:0] wd, smask, sclr, ep_act, ep_dir, en, iclr, done, nak, naken;
	logic [7:0] err, stl, ako, aki, opk, ipk, m, n, a, x;
	logic [7:0] mem [8];
	logic [27:0] lvl;
	logic [4:0] emask, eclr, efrc;
	logic [9:0] rcnt;
	wire sof, se0, tok, toko, rw, dp, pu_o, pad_o, rv, lrw, susp;
	wire irl, irm, irh;
	wire [1:0] resp;
	wire [3:0] besl, lbesl;
	wire [7:0] scause, spres, epen, epin, rd, sr, eflag;
	wire [4:0] raw, msk;
	wire [13:0] cl, cm, ch;
	int failures = 0, total_checks = 0, nr;
	always #5 clk = !clk;
	usbdec_host_model usbdec_host_model_inst (.clk_i(clk), .sof_o(sof),
		.se0_o(se0), .lpm_token_o(tok), .lpm_other_o(toko),
		.lpm_besl_o(besl), .lpm_rwake_o(rw), .dp_level_o(dp));
	usbdec_top #(.SUSPEND_CYCLES(50), .PERI_DIV(2)) usbdec_top_inst (
		.CLK_SYS_I(clk), .RSTN_I(rstn), .PULLUP_EN_I(pu),
		.PAD_FUNC_SEL_I(pad), .SUPPLY_LEVEL_I(sup), .SUPPLY_MASK_I(smask),
		.SUPPLY_CLR_I(sclr), .LPM_ENABLE_I(lpm_en), .LPM_HANDSHAKE_I(hs),
		.LPM_OTHER_RESP_I(oth), .LPM_TOKEN_I(tok), .LPM_OTHER_I(toko),
		.LPM_BESL_I(besl), .LPM_RWAKE_I(rw), .AUTO_MEM_I(auto_m),
		.ENDPOINT_ACTIVE_REG_I(ep_act), .EP_DIR_IN_I(ep_dir), .EP0_WR_I(e0wr),
		.EP0_WADDR_I(wa), .EP0_WDATA_I(wd), .EP0_RADDR_I(ra),
		.LVL_SEL_I(lvl), .ENG_MASK_I(emask), .ENG_CLR_I(eclr),
		.ENG_FORCE_I(efrc), .SOF_I(sof), .SE0_I(se0), .BUS_RST_CNT_I(rcnt),
		.DP_LEVEL_I(dp), .ACTIVE_MODE_I(act), .EP0_DONE_I(e0done),
		.EP0_SETUP_I(e0setup), .EP_INT_EN_I(en), .EP_INT_CLR_I(iclr),
		.EP_DONE_I(done), .EP_NAK_I(nak), .EP_NAK_EN_I(naken), .EP_ERR_I(err),
		.EP_STALL_BIT_I(stl), .EP_ACK_OUT_I(ako), .EP_ACK_IN_I(aki),
		.EP_OUT_PKT_I(opk), .EP_IN_PKT_I(ipk), .PULLUP_ON_O(pu_o),
		.PAD_GPIO_O(pad_o), .SUPPLY_CAUSE_O(scause), .SUPPLY_PRESENT_O(spres),
		.LPM_RESP_VALID_O(rv), .LPM_RESP_O(resp), .LPM_BESL_O(lbesl),
		.LPM_RWAKE_O(lrw), .EP_ENABLED_O(epen), .EP_IS_IN_O(epin),
		.EP0_RDATA_O(rd), .ENG_RAW_O(raw), .ENG_MASKED_O(msk),
		.EP_INT_SR_O(sr), .EP_ERR_FLAG_O(eflag), .SUSPEND_O(susp),
		.CAUSE_LOW_O(cl), .CAUSE_MED_O(cm), .CAUSE_HIGH_O(ch),
		.IRQ_LOW_O(irl), .IRQ_MED_O(irm), .IRQ_HIGH_O(irh));
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] s, e);
		total_checks++;
		if (s !== e) begin
			failures++;
			$display("wrong value %s expected %0h seen %0h", nm, e, s);
		end
	endtask : chk
	// inputs always move 1 ns after the edge, clear of sampling
	task automatic st(input int k = 1);
		repeat (k) @(posedge clk);
		#1;
	endtask : st
	// code 3 shares the high line with code 2
	function automatic logic [13:0] route(input logic [13:0] c, int ln);
		for (int i = 0; i < 14; i++)
			route[i] = c[i] && ((lvl[2*i+:2] > 2 ? 2 : lvl[2*i+:2]) == ln);
	endfunction : route
	task automatic lines(input logic [13:0] c);
		chk("cause_low", cl, route(c, 0));
		chk("cause_med", cm, route(c, 1));
		chk("cause_high", ch, route(c, 2));
		chk("irq", {irh, irm, irl}, {|route(c, 2), |route(c, 1), |route(c, 0)});
	endtask : lines
	task automatic eng_clr(input logic [4:0] v);
		eclr = v;
		st();
		eclr = 5'h00;
		st();
	endtask : eng_clr
	task automatic final_report;
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : final_report
	// the sequence needs about 250 cycles; far beyond that is a hang
	initial begin
		#200000;
		failures++;
		final_report();
	end
	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		{pu, pad, sup, lpm_en, auto_m, e0wr, e0done, e0setup, hs, oth, wa, ra,
			wd, smask, sclr, ep_act, ep_dir, en, iclr, done, nak, naken, err,
			stl, ako, aki, opk, ipk, lvl, emask, eclr, efrc} = '0;
		act = 1'b1;
		rcnt = 10'h008;
		void'($urandom(13653));
		st(3);
		rstn = 1'b1;
		for (int i = 0; i < 6; i++) begin
			// a random mask shows that only bit 5 of it gates the line
			smask = 8'($urandom);
			pu = 1'($urandom);
			pad = 1'($urandom);
			lvl = 28'($urandom);
			sup = !sup;
			st(2);
			chk("pullup", pu_o, pu);
			chk("pad", pad_o, pad);
			chk("present", spres, {2'h0, sup, 5'h00});
			chk("supply_cause", scause, 8'h20);
			lines(smask[5] ? 14'h0020 : 14'h0000);
			sclr = 8'h20;
			st();
			sclr = 8'h00;
			st();
			chk("supply_clear", scause, 8'h00);
		end
		$display("test pins and supply done");
		for (int i = 0; i < 8; i++) begin
			emask = 5'($urandom);
			lvl = 28'($urandom);
			usbdec_host_model_inst.sof();
			chk("sof_raw", raw, 5'h01);
			chk("sof_masked", msk, emask & 5'h01);
			chk("suspend_off", susp, 1'b0);
			lines({13'h0, emask[0]});
			eng_clr(5'h01);
			chk("sof_clear", raw, 5'h00);
		end
		$display("test frame start done");
		emask = 5'h1F;
		st(45);
		chk("suspend_early", susp, 1'b0);
		st(10);
		chk("suspend", susp, 1'b1);
		act = 1'b0;
		usbdec_host_model_inst.wake(3);
		chk("resume_sleep", raw[4], 1'b0);
		act = 1'b1;
		usbdec_host_model_inst.wake(3);
		chk("resume", {raw[4], msk[4]}, 2'h3);
		eng_clr(5'h10);
		// counts of 0 and 1 both fire on the first tick, so start at 2
		nr = 2 + $urandom % 11;
		rcnt = 10'(nr);
		usbdec_host_model_inst.se0(1'b1);
		st(2 * nr - 1);
		chk("bus_reset_early", raw[1], 1'b0);
		st(9);
		chk("bus_reset", {raw[1], msk[1], susp}, 3'h6);
		eng_clr(5'h02);
		st(20);
		chk("bus_reset_once", raw[1], 1'b0);
		usbdec_host_model_inst.se0(1'b0);
		eng_clr(5'h1F);
		$display("test suspend and bus reset done");
		for (int k = 0; k < 3; k++) begin
			lpm_en = (k == 0);
			hs = 2'($urandom);
			oth = 2'($urandom);
			b = 4'($urandom);
			usbdec_host_model_inst.tok(k == 2, b, b[0]);
			chk("lpm_valid", rv, 1'b1);
			chk("lpm_resp", resp, k == 2 ? oth : (lpm_en ? hs : 2'h0));
			if (k < 2) begin
				chk("link_pm_status_reg", {lrw, lbesl}, {b[0], b});
				chk("lpm_raw", {raw[3], msk[3]}, 2'h3);
			end
			eng_clr(5'h1F);
		end
		$display("test link power done");
		// activation is fixed before any endpoint traffic
		ep_act = 8'($urandom);
		ep_dir = 8'($urandom);
		auto_m = 1'b1;
		st(2);
		chk("ep_enabled", epen, ep_act);
		chk("ep_dir", epin, ep_dir);
		auto_m = 1'b0;
		st(2);
		chk("ep_manual", epen, 8'hFF);
		en = 8'($urandom);
		for (int k = 0; k < 5; k++) begin
			m = 8'($urandom);
			n = 8'($urandom);
			a = 8'($urandom);
			// first pass in automatic mode: inactive endpoints stay silent
			auto_m = (k == 0);
			{naken, stl, ako, aki} = {n, n, a, ~a};
			{done, nak, err, opk, ipk} = {k == 0 ? m : 8'h00, k == 1 ? m : 8'h00,
				k == 2 ? m : 8'h00, k == 3 ? m : 8'h00, k == 4 ? m : 8'h00};
			st();
			{done, nak, err, opk, ipk} = '0;
			st();
			x = k == 1 ? m & n : k == 3 ? m & n & a : k == 4 ? m & n & ~a : m;
			if (k == 0)
				x = x & ep_act;
			chk("ep_status", sr, x);
			chk("ep_error", eflag, k == 2 ? m : 8'h00);
			lines({x & en, 6'h00});
			iclr = 8'hFF;
			st();
			iclr = 8'h00;
			st();
			chk("ep_clear", sr, 8'h00);
		end
		for (int j = 0; j < 3; j++) begin
			e0done = (j == 0);
			e0setup = (j == 1);
			efrc = j == 2 ? 5'h04 : 5'h00;
			st();
			{e0done, e0setup, efrc} = '0;
			st();
			chk("ep0_event", raw, 5'h04);
			eng_clr(5'h04);
		end
		$display("test endpoints done");
		e0wr = 1'b1;
		for (int i = 0; i < 8; i++) begin
			wa = 3'(i);
			wd = 8'($urandom);
			mem[i] = wd;
			st();
		end
		e0wr = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			ra = 3'(i);
			st();
			chk("ep0_data", rd, mem[i]);
		end
		$display("test control store done");
		final_report();
	end
endmodule : usbdec_top_tb_top
